// file: rtl/countdown_and_tick_timer.sv
// countdown timer and second/minute tick interrupts of the clock chip
`timescale 1ns/1ns
module countdown_and_tick_timer
    import rtc_timer_pkg::*;
(
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       NRST,
    // 32.768 kHz oscillator, asynchronous to CLK
    input  wire logic       OSC_IN,
    // drift correction requests, one CLK pulse each
    input  wire logic       CORR_LENGTHEN,
    input  wire logic       CORR_SHORTEN,
    // decoded register access from the serial front end
    input  wire reg_req_t   REG_REQ,
    input  wire logic [3:0] REG_RADDR,
    output logic      [7:0] REG_RDATA,
    // open-drain active-low interrupt pin
    output logic            INT_N_OUT,
    output logic            INT_N_OE,
    // clock output selection handed to the divider
    output logic      [2:0] CLKOUT_SEL
);
    logic       osc_s1_q, osc_s2_q, osc_s3_q;
    logic       osc_tick;
    logic [8:0] pre_q;
    logic [6:0] sec_cnt_q;
    logic [5:0] min_cnt_q;
    logic       corr_len_q, corr_sht_q;
    logic       t4096, t64, t1, tmin;
    logic [6:0] sec_end;
    tcc_t       tcc_q;
    logic [7:0] n_q, cnt_q;
    logic       src_tick, cd_run, arm_q;
    logic       cd_evt, ms_evt;
    logic       cd_flag_q, ms_flag_q;
    logic       cd_flag_d, ms_flag_d;
    logic       long_en_q, short_en_q, pulse_mode_q, cd_ie_q;
    logic       wr_flags, wr_tcc, wr_cdv;
    logic       cd_pulse_q, ms_pulse_q;
    logic [9:0] cd_pw_q, ms_pw_q;
    logic [9:0] cd_width;
    logic       int_d;

    assign wr_flags = REG_REQ.wr && (REG_REQ.addr == ADDR_FLAGS);
    assign wr_tcc   = REG_REQ.wr && (REG_REQ.addr == ADDR_TCC);
    assign wr_cdv   = REG_REQ.wr && (REG_REQ.addr == ADDR_CDV);

    // oscillator pin through two stages before edge detection
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= OSC_IN;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end
    assign osc_tick = osc_s2_q && !osc_s3_q;

    assign t4096 = osc_tick && (pre_q[2:0] == PRE4096_END);
    assign t64   = osc_tick && (pre_q == PRE64_END);
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pre_q <= '0;
        end else if (osc_tick) begin
            pre_q <= pre_q + 9'h001;
        end
    end

    // correction stretches or trims the next second by one 64th
    always_comb begin
        sec_end = SEC_END;
        if (corr_len_q) begin
            sec_end = SEC_END_LNG;
        end else if (corr_sht_q) begin
            sec_end = SEC_END_SHT;
        end
    end
    assign t1   = t64 && (sec_cnt_q >= sec_end);
    assign tmin = t1 && (min_cnt_q == MIN_END);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            corr_len_q <= 1'b0;
            corr_sht_q <= 1'b0;
        end else begin
            // request arriving on the consuming second is kept
            corr_len_q <= CORR_LENGTHEN || (corr_len_q && !t1);
            corr_sht_q <= CORR_SHORTEN || (corr_sht_q && !t1);
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sec_cnt_q <= '0;
            min_cnt_q <= '0;
        end else if (t64) begin
            if (t1) begin
                sec_cnt_q <= '0;
                min_cnt_q <= tmin ? 6'h00 : min_cnt_q + 6'h01;
            end else begin
                sec_cnt_q <= sec_cnt_q + 7'h01;
            end
        end
    end

    always_comb begin
        case (tcc_q.countdown_src_sel)
            SRC_4096: src_tick = t4096;
            SRC_64:   src_tick = t64;
            SRC_1:    src_tick = t1;
            SRC_MIN:  src_tick = tmin;
            default:  src_tick = 1'b0;
        endcase
    end

    // reserved control bits forced to zero on write
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            tcc_q <= TCC_RESET;
        end else if (wr_tcc) begin
            tcc_q         <= tcc_t'(REG_REQ.wdata);
            tcc_q.unused7 <= 1'b0;
            tcc_q.unused2 <= 1'b0;
        end
    end

    // fast sources spend the first tick after enable arming
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            arm_q <= 1'b0;
        end else begin
            arm_q <= tcc_q.timer_enable && (arm_q || src_tick);
        end
    end
    // counts only when enabled and n is nonzero
    assign cd_run = src_tick && tcc_q.timer_enable && (n_q != CDV_ZERO)
                    && (arm_q || tcc_q.countdown_src_sel >= SRC_1);
    assign cd_evt = cd_run && (cnt_q == CDV_ONE);

    // binary down count, reload at one, writes act at once
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            n_q   <= CDV_ZERO;
            cnt_q <= CDV_ZERO;
        end else if (wr_cdv) begin
            n_q   <= REG_REQ.wdata;
            cnt_q <= REG_REQ.wdata;
        end else if (cd_run) begin
            if (cnt_q <= CDV_ONE) begin
                cnt_q <= n_q;
            end else begin
                cnt_q <= cnt_q - CDV_ONE;
            end
        end
    end

    // short tick wins over long tick
    assign ms_evt = short_en_q ? t1 : (long_en_q && tmin);

    // writes AND into flags; a same-cycle event still sets
    always_comb begin
        cd_flag_d = cd_flag_q;
        ms_flag_d = ms_flag_q;
        if (wr_flags) begin
            cd_flag_d = cd_flag_q && REG_REQ.wdata[B_CD_F];
            ms_flag_d = ms_flag_q && REG_REQ.wdata[B_TICK_F];
        end
        cd_flag_d = cd_flag_d || cd_evt;
        ms_flag_d = ms_flag_d || ms_evt;
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cd_flag_q    <= 1'b0;
            ms_flag_q    <= 1'b0;
            long_en_q    <= 1'b0;
            short_en_q   <= 1'b0;
            pulse_mode_q <= 1'b0;
            cd_ie_q      <= 1'b0;
        end else begin
            cd_flag_q <= cd_flag_d;
            ms_flag_q <= ms_flag_d;
            if (wr_flags) begin
                long_en_q    <= REG_REQ.wdata[B_LONG_EN];
                short_en_q   <= REG_REQ.wdata[B_SHORT_EN];
                pulse_mode_q <= REG_REQ.wdata[B_PULSE_M];
                cd_ie_q      <= REG_REQ.wdata[B_CD_IE];
            end
        end
    end

    // countdown pulse width by source and n
    always_comb begin
        case (tcc_q.countdown_src_sel)
            SRC_4096: cd_width = (n_q == CDV_ONE) ? PW_8192 : PW_4096;
            SRC_64:   cd_width = (n_q == CDV_ONE) ? PW_128 : PW_64;
            default:  cd_width = PW_64;
        endcase
    end

    // pulse per period, cut short when the flag is cleared
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cd_pulse_q <= 1'b0;
            cd_pw_q    <= '0;
        end else if (cd_evt) begin
            cd_pulse_q <= 1'b1;
            cd_pw_q    <= cd_width;
        end else if (!cd_flag_d) begin
            cd_pulse_q <= 1'b0;
        end else if (cd_pulse_q && osc_tick) begin
            cd_pw_q <= cd_pw_q - PW_ONE;
            if (cd_pw_q == PW_ONE) begin
                cd_pulse_q <= 1'b0;
            end
        end
    end

    // tick pulse restarts regardless of the flag's history
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ms_pulse_q <= 1'b0;
            ms_pw_q    <= '0;
        end else if (ms_evt) begin
            ms_pulse_q <= 1'b1;
            ms_pw_q    <= PW_64;
        end else if (!ms_flag_d) begin
            ms_pulse_q <= 1'b0;
        end else if (ms_pulse_q && osc_tick) begin
            ms_pw_q <= ms_pw_q - PW_ONE;
            if (ms_pw_q == PW_ONE) begin
                ms_pulse_q <= 1'b0;
            end
        end
    end

    // pulsed or level output; sources are wired-or
    assign int_d = (cd_ie_q && (pulse_mode_q ? cd_pulse_q : cd_flag_q))
                || ((long_en_q || short_en_q)
                    && (pulse_mode_q ? ms_pulse_q : ms_flag_q));

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            INT_N_OE   <= 1'b0;
            INT_N_OUT  <= 1'b0;
            CLKOUT_SEL <= '0;
        end else begin
            INT_N_OE   <= int_d;
            INT_N_OUT  <= 1'b0;
            CLKOUT_SEL <= tcc_q.clock_output_freq_sel;
        end
    end

    // live counter on read; unmapped addresses read zero
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            REG_RDATA <= '0;
        end else begin
            case (REG_RADDR)
                ADDR_FLAGS: REG_RDATA <= {long_en_q, short_en_q, ms_flag_q,
                                          pulse_mode_q, 1'b0, cd_flag_q,
                                          1'b0, cd_ie_q};
                ADDR_TCC:   REG_RDATA <= tcc_q;
                ADDR_CDV:   REG_RDATA <= cnt_q;
                default:    REG_RDATA <= '0;
            endcase
        end
    end

    a_cd_flag_set: assert property (@(posedge CLK) disable iff (!NRST)
        cd_evt |=> cd_flag_q)
        else $error("countdown flag not set at end of period");

    a_cd_reload: assert property (@(posedge CLK) disable iff (!NRST)
        cd_evt && !wr_cdv |=> cnt_q == $past(n_q))
        else $error("counter did not reload n");

    a_cd_step: assert property (@(posedge CLK) disable iff (!NRST)
        cd_run && cnt_q > CDV_ONE && !wr_cdv
        |=> cnt_q == $past(cnt_q) - CDV_ONE)
        else $error("counter did not step down by one");

    a_cd_hold: assert property (@(posedge CLK) disable iff (!NRST)
        (!tcc_q.timer_enable || n_q == CDV_ZERO) && !wr_cdv |=> $stable(cnt_q))
        else $error("counter moved while stopped");

    a_cd_sticky: assert property (@(posedge CLK) disable iff (!NRST)
        cd_flag_q && !wr_flags |=> cd_flag_q)
        else $error("countdown flag cleared by hardware");

    a_flag_and: assert property (@(posedge CLK) disable iff (!NRST)
        wr_flags && !REG_REQ.wdata[B_TICK_F] && !ms_evt |=> !ms_flag_q)
        else $error("tick flag not cleared by zero write");

    a_tick_none: assert property (@(posedge CLK) disable iff (!NRST)
        !long_en_q && !short_en_q |-> !ms_evt)
        else $error("tick event with both tick enables off");

    a_level_int: assert property (@(posedge CLK) disable iff (!NRST)
        !pulse_mode_q && cd_ie_q && cd_flag_q |=> INT_N_OE)
        else $error("level interrupt not driven");

    a_pulse_cut: assert property (@(posedge CLK) disable iff (!NRST)
        cd_pulse_q && !cd_flag_d && !cd_evt |=> !cd_pulse_q)
        else $error("pulse not ended by flag clear");

    a_tick_pulse: assert property (@(posedge CLK) disable iff (!NRST)
        ms_evt |=> ms_pulse_q && ms_pw_q == PW_64)
        else $error("tick pulse not started at full width");
endmodule

// file: shared/rtc_timer_pkg.sv
// constants and carrier types for the countdown and tick timer
package rtc_timer_pkg;
    // register addresses seen through the serial front end
    localparam logic [3:0] ADDR_FLAGS = 4'h1;
    localparam logic [3:0] ADDR_TCC   = 4'he;
    localparam logic [3:0] ADDR_CDV   = 4'hf;

    // flag register bit positions
    localparam int B_LONG_EN  = 7;
    localparam int B_SHORT_EN = 6;
    localparam int B_TICK_F   = 5;
    localparam int B_PULSE_M  = 4;
    localparam int B_CD_F     = 2;
    localparam int B_CD_IE    = 0;

    // countdown source codes
    localparam logic [1:0] SRC_4096 = 2'h0;
    localparam logic [1:0] SRC_64   = 2'h1;
    localparam logic [1:0] SRC_1    = 2'h2;
    localparam logic [1:0] SRC_MIN  = 2'h3;

    // prescaler taps on the 32.768 kHz oscillator
    localparam int         OSC_HZ      = 32768;
    localparam logic [2:0] PRE4096_END = 3'h7;
    localparam logic [8:0] PRE64_END   = 9'h1ff;
    localparam logic [6:0] SEC_END     = 7'h3f;
    localparam logic [6:0] SEC_END_LNG = 7'h40;
    localparam logic [6:0] SEC_END_SHT = 7'h3e;
    localparam logic [5:0] MIN_END     = 6'h3b;

    // interrupt pulse widths in oscillator cycles
    localparam logic [9:0] PW_8192 = 10'(OSC_HZ / 8192);
    localparam logic [9:0] PW_4096 = 10'(OSC_HZ / 4096);
    localparam logic [9:0] PW_128  = 10'(OSC_HZ / 128);
    localparam logic [9:0] PW_64   = 10'(OSC_HZ / 64);

    localparam logic [7:0] CDV_ONE   = 8'h01;
    localparam logic [7:0] CDV_ZERO  = 8'h00;
    localparam logic [9:0] PW_ONE    = 10'h001;

    typedef struct packed {
        logic       unused7;
        logic [2:0] clock_output_freq_sel;
        logic       timer_enable;
        logic       unused2;
        logic [1:0] countdown_src_sel;
    } tcc_t;

    // source left at the slowest setting after reset
    localparam tcc_t TCC_RESET = '{1'b0, 3'h0, 1'b0, 1'b0, SRC_MIN};

    typedef struct packed {
        logic       wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

// file: verification/host_model.sv
// host side model: register requests and the 32.768 kHz oscillator
`timescale 1ns/1ns
module host_model
    import rtc_timer_pkg::*;
(
    // clock and returned data
    input  wire logic       CLK,
    input  wire logic [7:0] REG_RDATA,
    // requests and oscillator
    output reg_req_t        REG_REQ,
    output logic      [3:0] REG_RADDR,
    output logic            OSC_IN
);
    // oscillator sped up to one rising edge per two clocks
    initial begin
        REG_REQ = '0;
        REG_RADDR = 4'h0;
        OSC_IN = 1'b0;
        forever begin
            @(posedge CLK);
            #1 OSC_IN = ~OSC_IN;
        end
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK);
        #1 REG_REQ = '{1'b1, a, d};
        @(posedge CLK);
        // stale address and data inverted once released
        #1 REG_REQ = '{1'b0, ~a, ~d};
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge CLK);
        #1 REG_RADDR = a;
        @(posedge CLK);
        #1 d = REG_RDATA;
        REG_RADDR = ~a;
    endtask

    task automatic rd_live(output logic [7:0] d);
        logic [7:0] d2;
        rd(ADDR_CDV, d);
        rd(ADDR_CDV, d2);
        if (d2 !== d) rd(ADDR_CDV, d);
    endtask
endmodule

// file: verification/countdown_and_tick_timer_bench.sv
// self-checking bench for the countdown and tick timer
`timescale 1ns/1ns
module countdown_and_tick_timer_bench
    import rtc_timer_pkg::*;
;
    logic       clk;
    logic       nrst;
    logic       osc;
    logic       corr_sht;
    reg_req_t   req;
    logic [3:0] raddr;
    logic [7:0] rdata;
    logic       int_n;
    logic       int_oe;
    logic [2:0] clkout_sel;
    int         n_fail;
    int         n_compared;
    int         cyc;
    time        t0;
    logic [7:0] v;

    countdown_and_tick_timer countdown_and_tick_timer_inst (
        .CLK(clk), .NRST(nrst), .OSC_IN(osc), .CORR_LENGTHEN(1'b0),
        .CORR_SHORTEN(corr_sht), .REG_REQ(req), .REG_RADDR(raddr),
        .REG_RDATA(rdata), .INT_N_OUT(int_n), .INT_N_OE(int_oe),
        .CLKOUT_SEL(clkout_sel));

    host_model host_model_inst (
        .CLK(clk), .REG_RDATA(rdata), .REG_REQ(req),
        .REG_RADDR(raddr), .OSC_IN(osc));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string msg);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask

    task automatic near(input int lo, input int hi, input string msg);
        check(8'(cyc >= lo && cyc <= hi), 8'h01, msg);
    endtask

    task automatic w(input logic [3:0] a, input logic [7:0] d);
        host_model_inst.wr(a, d);
    endtask

    task automatic r(input logic [3:0] a);
        host_model_inst.rd(a, v);
    endtask

    // bounded wait for the interrupt pin enable to reach val
    task automatic wait_oe(input logic val, input int lim);
        cyc = 0;
        while (int_oe !== val && cyc < lim) begin
            @(posedge clk);
            #1 cyc++;
        end
        if (cyc >= lim) check(8'(int_oe), 8'(val), "irq wait");
    endtask

    task automatic t_reset;
        r(ADDR_TCC);
        check(v, 8'h03, "ctrl reset");
        r(ADDR_CDV);
        check(v, 8'h00, "count reset");
        r(ADDR_FLAGS);
        check(v, 8'h00, "flags reset");
        r(4'h5);
        check(v, 8'h00, "unmapped read");
        check(8'({int_oe, int_n}), 8'h00, "irq idle");
        w(ADDR_TCC, 8'hff);
        r(ADDR_TCC);
        check(v, 8'h7b, "reserved bits");
        check(8'(clkout_sel), 8'h07, "clkout copy");
        w(ADDR_TCC, 8'h03);
        $display("test reset done");
    endtask

    task automatic t_level;
        w(ADDR_FLAGS, 8'h01);
        w(ADDR_TCC, 8'h00);
        w(ADDR_CDV, 8'h03);
        w(ADDR_TCC, 8'h08);
        wait_oe(1'b1, 200);
        t0 = $time;
        w(ADDR_FLAGS, 8'h01);
        wait_oe(1'b0, 4);
        wait_oe(1'b1, 100);
        cyc = int'(($time - t0) / 50);
        near(47, 49, "period n=3");
        repeat (20) @(posedge clk);
        r(ADDR_CDV);
        check(v, 8'h02, "live count");
        r(ADDR_FLAGS);
        check(v, 8'h05, "flag held");
        w(ADDR_FLAGS, 8'h00);
        repeat (100) @(posedge clk);
        #1 check(8'(int_oe), 8'h00, "irq gated");
        r(ADDR_FLAGS);
        check(v, 8'h04, "flag set again");
        w(ADDR_CDV, 8'h05);
        host_model_inst.rd_live(v);
        check(8'(v == 8'h05 || v == 8'h04), 8'h01, "new n live");
        w(ADDR_TCC, 8'h00);
        w(ADDR_FLAGS, 8'h01);
        repeat (200) @(posedge clk);
        r(ADDR_FLAGS);
        check(v, 8'h01, "disabled");
        w(ADDR_CDV, 8'h00);
        w(ADDR_TCC, 8'h08);
        repeat (200) @(posedge clk);
        r(ADDR_FLAGS);
        check(v, 8'h01, "n zero stops");
        $display("test level done");
    endtask

    task automatic t_pulse;
        w(ADDR_TCC, 8'h00);
        w(ADDR_CDV, 8'h01);
        w(ADDR_FLAGS, 8'h11);
        w(ADDR_TCC, 8'h08);
        wait_oe(1'b1, 200);
        near(18, 33, "first period");
        wait_oe(1'b0, 40);
        near(5, 11, "pulse n=1");
        r(ADDR_FLAGS);
        check(v, 8'h15, "flag after pulse");
        w(ADDR_TCC, 8'h00);
        w(ADDR_CDV, 8'h02);
        w(ADDR_FLAGS, 8'h11);
        w(ADDR_TCC, 8'h08);
        wait_oe(1'b1, 200);
        wait_oe(1'b0, 40);
        near(13, 19, "pulse n=2");
        w(ADDR_TCC, 8'h01);
        w(ADDR_FLAGS, 8'h11);
        w(ADDR_TCC, 8'h09);
        wait_oe(1'b1, 5000);
        t0 = $time;
        repeat (20) @(posedge clk);
        w(ADDR_FLAGS, 8'h11);
        wait_oe(1'b0, 4);
        wait_oe(1'b1, 3000);
        cyc = int'(($time - t0) / 50);
        near(2046, 2050, "64 Hz period");
        w(ADDR_TCC, 8'h03);
        $display("test pulse done");
    endtask

    task automatic t_tick;
        w(ADDR_FLAGS, 8'h50);
        corr_sht = 1'b1;
        @(posedge clk);
        #1 corr_sht = 1'b0;
        wait_oe(1'b1, 70000);
        t0 = $time;
        r(ADDR_FLAGS);
        check(v, 8'h70, "tick flag");
        w(ADDR_FLAGS, 8'h70);
        r(ADDR_FLAGS);
        check(v, 8'h70, "one keeps flag");
        wait_oe(1'b0, 1100);
        cyc = int'(($time - t0) / 50);
        near(1020, 1028, "tick pulse");
        w(ADDR_FLAGS, 8'h50);
        r(ADDR_FLAGS);
        check(v, 8'h50, "tick clear");
        $display("test tick done");
    endtask

    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        corr_sht = 1'b0;
        n_fail = 0;
        n_compared = 0;
        repeat (16) @(posedge clk);
        #1 nrst = 1'b1;
        t_reset;
        t_level;
        t_pulse;
        t_tick;
        end_sim;
    end

    // about 66k cycles expected, mostly the one-second tick
    initial begin
        repeat (95000) @(posedge clk);
        n_fail++;
        end_sim;
    end
endmodule
